// File: core/sequencer_defs.svh
// offsets, field positions, reset values and timing counts of the sequencer
`ifndef SEQUENCER_DEFS_SVH
`define SEQUENCER_DEFS_SVH

// clock rate in kHz, 20 MHz core clock
`define CLK_KHZ 20000

// register offsets
`define REG_FAULT_ADDR 8'h01
`define REG_STATUS_ADDR 8'h02
`define REG_CTRL_ADDR 8'h04
`define REG_SHDN_ADDR 8'h05
`define REG_RESET_ADDR 8'h06

// software reset code, value is arbitrary
`define RESET_CODE 8'hC5

// status register fields
`define ST_READY_BIT 0
`define ST_UVLO_BIT 1
`define ST_OT_BIT 2

// fault register fields
`define FLT_UVLO_BIT 1
`define FLT_OT_BIT 2

// control and shutdown register fields
`define CTRL_EN_BIT 0
`define SHDN_SEL_LSB 0
`define SHDN_SEL_MSB 1
`define SHDN_RAMP_BIT 2

// discharge select codes
`define SEL_OPEN 2'h0
`define SEL_50R 2'h1
`define SEL_100R 2'h2
`define SEL_200R 2'h3
`define SHDN_SEL_RST `SEL_100R
`define SHDN_RAMP_RST 1'b0

// times in their own units
`define SCL_LOW_MS 100
`define FAULT_WAIT_MS 20
`define SOFT_START_US 520
`define PD_DELAY_US 2
`define HOST_SETTLE_US 20

// times as clock cycles
`define SCL_LOW_CYC (`SCL_LOW_MS * `CLK_KHZ)
`define FAULT_WAIT_CYC (`FAULT_WAIT_MS * `CLK_KHZ)
`define SOFT_START_CYC ((`SOFT_START_US * `CLK_KHZ + 999) / 1000)
`define PD_DELAY_CYC ((`PD_DELAY_US * `CLK_KHZ) / 1000)

`endif

// File: core/sequencer_pkg.sv
// types shared by the sequencer files
package sequencer_pkg;

    typedef enum logic [1:0] {
        ST_RESET,
        ST_IDLE,
        ST_ACTIVE
    } state_type;

    typedef logic [7:0] reg_byte_type;

endpackage : sequencer_pkg

// File: core/interval_timer.sv
// one-shot down counter with busy level and expiry pulse
`timescale 1ns/1ps

module interval_timer #(
    parameter int CNT_W = 21
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic start_i,
    input wire logic stop_i,
    input wire logic [CNT_W-1:0] count_i,
    output logic busy_o,
    output logic done_o
);

    logic [CNT_W-1:0] cnt_q;

    // start wins over stop so a restart in the same cycle is never lost
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            cnt_q <= '0;
            busy_o <= 1'b0;
        end else if (start_i) begin
            cnt_q <= count_i;
            busy_o <= 1'b1;
        end else if (stop_i) begin
            busy_o <= 1'b0;
        end else if (busy_o) begin
            cnt_q <= cnt_q - 1'b1;
            if (cnt_q <= 1) begin
                busy_o <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            done_o <= 1'b0;
        end else begin
            done_o <= busy_o && !start_i && !stop_i && (cnt_q <= 1);
        end
    end

endmodule : interval_timer

// File: core/regulator_state_sequencer.sv
// reset, idle and active sequencing of the step-down regulator control core
`timescale 1ns/1ps
`include "sequencer_defs.svh"
// Contract
// - after reset stay in Reset while clock low
// - Reset holds defaults, no register access
// - reset code or long clock low enters Reset
// - software reset passes Reset briefly into Idle
// - clock-low reset powers down housekeeping, waits
// - ready after housekeeping stable, enable to Active
// - Idle: access allowed, comparator armed, ready
// - low input entering Idle raises undervoltage fault
// - fault entry to Idle waits 20 ms
// - enable during fault is cleared at once
// - falling undervoltage in Active returns to Idle
// - over-temperature in Active returns to Idle
// - status follows condition, fault sticky until read
// - enable starts soft-start ramp of 520 us
// - disable tristates, discharges unless select 00
// - pull-down on within 2 us of disable
// - select picks 50, 100, 200 ohm or open
// - ramp discharge bit pulls down on falling steps

module regulator_state_sequencer #(
    parameter int SCL_LOW_CYCLES = `SCL_LOW_CYC,
    parameter int FAULT_WAIT_CYCLES = `FAULT_WAIT_CYC,
    parameter int SOFT_START_CYCLES = `SOFT_START_CYC,
    parameter int CNT_W = 21
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic scl_i,
    input wire logic vin_above_rise_i,
    input wire logic vin_below_fall_i,
    input wire logic over_temp_i,
    input wire logic hk_stable_i,
    input wire logic dvs_falling_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    output logic reg_rvalid_o,
    output logic [1:0] state_o,
    output logic ready_o,
    output logic hk_power_o,
    output logic uvlo_arm_o,
    output logic buck_en_o,
    output logic soft_start_o,
    output logic pulldown_en_o,
    output logic [1:0] pulldown_sel_o
);

    localparam int NSYNC = 5;
    localparam int PD_COUNT = `PD_DELAY_CYC - 2;

    // asynchronous inputs: three flops, accepted once stages two and three agree
    logic [NSYNC-1:0] raw_in;
    logic [NSYNC-1:0] filt;

    assign raw_in = {hk_stable_i, over_temp_i, vin_below_fall_i, vin_above_rise_i, scl_i};

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            logic meta_q;
            logic s2_q;
            logic s3_q;
            logic f_q;
            always_ff @(posedge clock_i) begin
                if (!rst_n_i) begin
                    meta_q <= 1'b0;
                    s2_q <= 1'b0;
                    s3_q <= 1'b0;
                    f_q <= 1'b0;
                end else begin
                    meta_q <= raw_in[gi];
                    s2_q <= meta_q;
                    s3_q <= s2_q;
                    if (s2_q == s3_q) begin
                        f_q <= s3_q;
                    end
                end
            end
            assign filt[gi] = f_q;
        end
    endgenerate

    logic scl_high;
    logic vin_ok;
    logic vin_low;
    logic hot;
    logic hk_ok;

    assign scl_high = filt[0];
    assign vin_ok = filt[1];
    assign vin_low = filt[2];
    assign hot = filt[3];
    assign hk_ok = filt[4];

    sequencer_pkg::state_type state_q;
    sequencer_pkg::state_type state_d;

    logic sw_pend_q;
    logic enter_idle_q;
    logic hk_on_q;
    logic en_q;
    logic [1:0] sel_q;
    logic ramp_q;
    logic uvlo_fault_q;
    logic ot_fault_q;
    logic ready_q;
    logic pd_on_q;
    logic scl_busy;
    logic scl_expired;
    logic wait_busy;
    logic ss_busy;
    logic pd_done;

    // register access decode; nothing is taken while in Reset
    logic regs_open;
    logic wr_ok;
    logic wr_ctrl;
    logic en_req;
    logic dis_req;
    logic sw_rst;
    logic rd_fault;
    logic uvlo_cond;
    logic leave_active;
    logic enter_active;
    logic fault_to_idle;

    assign regs_open = (state_q != sequencer_pkg::ST_RESET);
    assign wr_ok = reg_wr_i && regs_open;
    assign wr_ctrl = wr_ok && (reg_addr_i == `REG_CTRL_ADDR);
    assign en_req = wr_ctrl && reg_wdata_i[`CTRL_EN_BIT];
    assign dis_req = wr_ctrl && !reg_wdata_i[`CTRL_EN_BIT];
    assign sw_rst = wr_ok && (reg_addr_i == `REG_RESET_ADDR) && (reg_wdata_i == `RESET_CODE);
    assign rd_fault = reg_rd_i && regs_open && (reg_addr_i == `REG_FAULT_ADDR);

    // idle checks the rising threshold, active only the falling one
    assign uvlo_cond = regs_open &&
        ((state_q == sequencer_pkg::ST_ACTIVE) ? vin_low : !vin_ok);

    assign leave_active = (state_q == sequencer_pkg::ST_ACTIVE) &&
        (state_d != sequencer_pkg::ST_ACTIVE);
    assign enter_active = (state_q != sequencer_pkg::ST_ACTIVE) &&
        (state_d == sequencer_pkg::ST_ACTIVE);
    assign fault_to_idle = (leave_active && (state_d == sequencer_pkg::ST_IDLE) &&
        (uvlo_cond || hot)) || (enter_idle_q && (!vin_ok || hot));

    always_comb begin
        state_d = state_q;
        case (state_q)
            sequencer_pkg::ST_RESET: begin
                if (sw_pend_q || scl_high) begin
                    state_d = sequencer_pkg::ST_IDLE;
                end
            end
            sequencer_pkg::ST_IDLE: begin
                if (sw_rst || scl_expired) begin
                    state_d = sequencer_pkg::ST_RESET;
                end else if (en_req && !uvlo_cond && !hot) begin
                    state_d = sequencer_pkg::ST_ACTIVE;
                end
            end
            sequencer_pkg::ST_ACTIVE: begin
                if (sw_rst || scl_expired) begin
                    state_d = sequencer_pkg::ST_RESET;
                end else if (dis_req || uvlo_cond || hot) begin
                    state_d = sequencer_pkg::ST_IDLE;
                end
            end
            default: begin
                state_d = sequencer_pkg::ST_RESET;
            end
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            state_q <= sequencer_pkg::ST_RESET;
            state_o <= 2'h0;
            uvlo_arm_o <= 1'b0;
        end else begin
            state_q <= state_d;
            state_o <= 2'(state_d);
            uvlo_arm_o <= (state_d != sequencer_pkg::ST_RESET);
        end
    end

    // software reset only lingers in Reset for the one clearing cycle
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            sw_pend_q <= 1'b0;
        end else begin
            sw_pend_q <= sw_rst;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            enter_idle_q <= 1'b0;
        end else begin
            enter_idle_q <= (state_q == sequencer_pkg::ST_RESET) &&
                (state_d == sequencer_pkg::ST_IDLE);
        end
    end

    // housekeeping stays off through a clock-low reset until the line is released
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            hk_on_q <= 1'b1;
        end else if (scl_expired && regs_open) begin
            hk_on_q <= 1'b0;
        end else if (state_q == sequencer_pkg::ST_RESET && scl_high) begin
            hk_on_q <= 1'b1;
        end
    end

    assign hk_power_o = hk_on_q;

    // the enable bit mirrors Active; a rejected write of 1 never sticks
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            en_q <= 1'b0;
            buck_en_o <= 1'b0;
        end else begin
            en_q <= (state_d == sequencer_pkg::ST_ACTIVE);
            buck_en_o <= (state_d == sequencer_pkg::ST_ACTIVE);
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i || !regs_open) begin
            sel_q <= `SHDN_SEL_RST;
            ramp_q <= `SHDN_RAMP_RST;
        end else if (wr_ok && reg_addr_i == `REG_SHDN_ADDR) begin
            sel_q <= reg_wdata_i[`SHDN_SEL_MSB:`SHDN_SEL_LSB];
            ramp_q <= reg_wdata_i[`SHDN_RAMP_BIT];
        end
    end

    // sticky faults: a new event in the read cycle survives the clear
    always_ff @(posedge clock_i) begin
        if (!rst_n_i || !regs_open) begin
            uvlo_fault_q <= 1'b0;
        end else if ((enter_idle_q && !vin_ok) || (en_req && uvlo_cond) ||
            (state_q == sequencer_pkg::ST_ACTIVE && vin_low)) begin
            uvlo_fault_q <= 1'b1;
        end else if (rd_fault) begin
            uvlo_fault_q <= 1'b0;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i || !regs_open) begin
            ot_fault_q <= 1'b0;
        end else if (hot) begin
            ot_fault_q <= 1'b1;
        end else if (rd_fault) begin
            ot_fault_q <= 1'b0;
        end
    end

    // ready stays low through the fault wait even if the fault clears early
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            ready_q <= 1'b0;
        end else begin
            ready_q <= (state_d != sequencer_pkg::ST_RESET) && hk_ok && hk_on_q &&
                !uvlo_cond && !hot && !wait_busy && !fault_to_idle;
        end
    end

    assign ready_o = ready_q;

    // register read port: one-cycle answer, silent while in Reset
    sequencer_pkg::reg_byte_type rd_d;

    always_comb begin
        rd_d = 8'h00;
        case (reg_addr_i)
            `REG_FAULT_ADDR: begin
                rd_d[`FLT_UVLO_BIT] = uvlo_fault_q;
                rd_d[`FLT_OT_BIT] = ot_fault_q;
            end
            `REG_STATUS_ADDR: begin
                rd_d[`ST_READY_BIT] = ready_q;
                rd_d[`ST_UVLO_BIT] = uvlo_cond;
                rd_d[`ST_OT_BIT] = hot;
            end
            `REG_CTRL_ADDR: begin
                rd_d[`CTRL_EN_BIT] = en_q;
            end
            `REG_SHDN_ADDR: begin
                rd_d[`SHDN_SEL_MSB:`SHDN_SEL_LSB] = sel_q;
                rd_d[`SHDN_RAMP_BIT] = ramp_q;
            end
            default: begin
                rd_d = 8'h00;
            end
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= 8'h00;
            reg_rvalid_o <= 1'b0;
        end else begin
            reg_rvalid_o <= reg_rd_i && regs_open;
            if (reg_rd_i && regs_open) begin
                reg_rdata_o <= rd_d;
            end
        end
    end

    // a glitch-free high level of the clock line reloads the low timer
    interval_timer #(.CNT_W(CNT_W)) u_scl_timer (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .start_i(regs_open && !scl_high && !scl_busy),
        .stop_i(scl_high || !regs_open),
        .count_i(CNT_W'(SCL_LOW_CYCLES)),
        .busy_o(scl_busy),
        .done_o(scl_expired)
    );

    interval_timer #(.CNT_W(CNT_W)) u_fault_wait (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .start_i(fault_to_idle),
        .stop_i(!regs_open),
        .count_i(CNT_W'(FAULT_WAIT_CYCLES)),
        .busy_o(wait_busy),
        .done_o()
    );

    // soft-start runs only while Active; leaving early abandons the ramp
    interval_timer #(.CNT_W(CNT_W)) u_soft_start (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .start_i(enter_active),
        .stop_i(leave_active),
        .count_i(CNT_W'(SOFT_START_CYCLES)),
        .busy_o(ss_busy),
        .done_o()
    );

    assign soft_start_o = ss_busy;

    interval_timer #(.CNT_W(CNT_W)) u_pd_delay (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .start_i(leave_active),
        .stop_i(enter_active),
        .count_i(CNT_W'(PD_COUNT)),
        .busy_o(),
        .done_o(pd_done)
    );

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            pd_on_q <= 1'b0;
        end else if (enter_active) begin
            pd_on_q <= 1'b0;
        end else if (pd_done) begin
            pd_on_q <= 1'b1;
        end
    end

    // select 00 means open: no internal discharge, output left to the load
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            pulldown_en_o <= 1'b0;
            pulldown_sel_o <= `SHDN_SEL_RST;
        end else begin
            pulldown_sel_o <= sel_q;
            pulldown_en_o <= (sel_q != `SEL_OPEN) && (pd_on_q ||
                (ramp_q && dvs_falling_i && state_q == sequencer_pkg::ST_ACTIVE));
        end
    end

endmodule : regulator_state_sequencer

// File: dv/regulator_state_sequencer_properties.sv
// port-level assertions for the regulator state sequencer
`timescale 1ns/1ps
`include "sequencer_defs.svh"
module regulator_state_sequencer_properties #(
    parameter int SCL_LOW_CYCLES = 200,
    parameter int SOFT_START_CYCLES = 30
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic scl_i,
    input wire logic dvs_falling_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_rvalid_o,
    input wire logic [1:0] state_o,
    input wire logic ready_o,
    input wire logic hk_power_o,
    input wire logic uvlo_arm_o,
    input wire logic buck_en_o,
    input wire logic soft_start_o,
    input wire logic pulldown_en_o,
    input wire logic [1:0] pulldown_sel_o
);
    localparam logic [1:0] S_RST = sequencer_pkg::ST_RESET;
    localparam logic [1:0] S_IDL = sequencer_pkg::ST_IDLE;
    localparam logic [1:0] S_ACT = sequencer_pkg::ST_ACTIVE;
    // raw low time of the line; the device sees it a few cycles late, so it can only be longer
    int unsigned low_q;
    always_ff @(posedge clock_i) begin
        if (!rst_n_i || scl_i) begin
            low_q <= 0;
        end else begin
            low_q <= low_q + 1;
        end
    end
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    chk_read_answer: assert property (reg_rd_i && state_o != S_RST |=> reg_rvalid_o)
        else $error("read not answered one cycle later");
    chk_reset_refuse: assert property (reg_rd_i && state_o == S_RST |=> !reg_rvalid_o)
        else $error("read answered while in reset");
    chk_reset_quiet: assert property (state_o == S_RST |-> !buck_en_o && !ready_o && !uvlo_arm_o)
        else $error("outputs active while in reset");
    chk_sw_reset: assert property (reg_wr_i && reg_addr_i == `REG_RESET_ADDR
        && reg_wdata_i == `RESET_CODE && state_o != S_RST |=> state_o == S_RST ##1 state_o == S_IDL)
        else $error("software reset did not pass reset into idle");
    chk_enable_cause: assert property (state_o == S_ACT && $past(state_o) != S_ACT |->
        $past(reg_wr_i) && $past(reg_addr_i) == `REG_CTRL_ADDR && $past(reg_wdata_i) ==? 8'b???????1
        && buck_en_o && soft_start_o)
        else $error("active entered without an enable write");
    chk_soft_start_len: assert property ($rose(soft_start_o) |-> ##[1:SOFT_START_CYCLES] !soft_start_o)
        else $error("soft start runs too long");
    chk_soft_start_min: assert property ($fell(soft_start_o) && state_o == S_ACT
        |-> $past(soft_start_o, SOFT_START_CYCLES))
        else $error("soft start ended early");
    chk_pulldown_on: assert property ($fell(buck_en_o) && pulldown_sel_o != `SEL_OPEN
        |-> ##[1:40] pulldown_en_o)
        else $error("pull-down late after disable");
    chk_open_no_pd: assert property ($fell(buck_en_o) && pulldown_sel_o == `SEL_OPEN
        |-> !pulldown_en_o [*8])
        else $error("pull-down on with open select");
    chk_ramp_pd: assert property (state_o == S_ACT && $past(state_o, 2) == S_ACT && pulldown_en_o
        |-> $past(dvs_falling_i))
        else $error("pull-down in active without a falling step");
    chk_scl_timer: assert property ($fell(hk_power_o) |-> state_o == S_RST && low_q >= SCL_LOW_CYCLES)
        else $error("housekeeping off without a long line low");
endmodule : regulator_state_sequencer_properties

bind regulator_state_sequencer regulator_state_sequencer_properties #(
    .SCL_LOW_CYCLES(SCL_LOW_CYCLES),
    .SOFT_START_CYCLES(SOFT_START_CYCLES)
) regulator_state_sequencer_properties_i (
    .clock_i, .rst_n_i, .scl_i, .dvs_falling_i, .reg_wr_i, .reg_rd_i, .reg_addr_i,
    .reg_wdata_i, .reg_rvalid_o, .state_o, .ready_o, .hk_power_o, .uvlo_arm_o, .buck_en_o,
    .soft_start_o, .pulldown_en_o, .pulldown_sel_o
);

// File: dv/regulator_host_model.sv
// host side model: drives the clock line and the register strobes
`timescale 1ns/1ps
module regulator_host_model (
    input wire logic clock_i,
    input wire logic [7:0] reg_rdata_i,
    input wire logic reg_rvalid_i,
    output logic scl_o,
    output logic reg_wr_o,
    output logic reg_rd_o,
    output logic [7:0] reg_addr_o,
    output logic [7:0] reg_wdata_o
);
    initial begin
        scl_o = 1'b0;
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        reg_addr_o = 8'h00;
        reg_wdata_o = 8'h00;
    end
    // idle address and data show the inverse so nothing leans on stale values
    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        @(posedge clock_i);
        reg_wr_o <= 1'b1;
        reg_addr_o <= addr;
        reg_wdata_o <= data;
        @(posedge clock_i);
        reg_wr_o <= 1'b0;
        reg_addr_o <= ~addr;
        reg_wdata_o <= ~data;
    endtask : write_reg
    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data, output logic ok);
        @(posedge clock_i);
        reg_rd_o <= 1'b1;
        reg_addr_o <= addr;
        @(posedge clock_i);
        reg_rd_o <= 1'b0;
        reg_addr_o <= ~addr;
        #1;
        ok = reg_rvalid_i;
        data = reg_rdata_i;
    endtask : read_reg
    task automatic pull_scl(input int cycles);
        @(posedge clock_i);
        scl_o <= 1'b0;
        repeat (cycles) @(posedge clock_i);
    endtask : pull_scl
    // commands sooner than the settle time may be misread by the device
    task automatic release_scl(input int settle);
        @(posedge clock_i);
        scl_o <= 1'b1;
        repeat (settle) @(posedge clock_i);
        #1;
    endtask : release_scl
endmodule : regulator_host_model

// File: dv/regulator_state_sequencer_bench.sv
// self-checking bench for the regulator state sequencer
`timescale 1ns/1ps
`include "sequencer_defs.svh"
module regulator_state_sequencer_bench;
    localparam int SS = 30;
    localparam int FW = 50;
    localparam logic [7:0] RST = 8'(sequencer_pkg::ST_RESET);
    localparam logic [7:0] IDL = 8'(sequencer_pkg::ST_IDLE);
    localparam logic [7:0] ACT = 8'(sequencer_pkg::ST_ACTIVE);
    localparam logic [7:0] CTRL = `REG_CTRL_ADDR;
    localparam logic [7:0] SHDN = `REG_SHDN_ADDR;
    typedef struct packed {logic wr; logic [7:0] addr; logic [7:0] data; logic [7:0] exp;} row_type;
    row_type rows [8] = '{'{1'b1, SHDN, 8'h00, 8'h00}, '{1'b1, SHDN, 8'h01, 8'h01},
        '{1'b1, SHDN, 8'h03, 8'h03}, '{1'b1, SHDN, 8'h06, 8'h06}, '{1'b0, 8'h02, 8'h00, 8'h01},
        '{1'b0, 8'h01, 8'h00, 8'h00}, '{1'b0, 8'h33, 8'h00, 8'h00}, '{1'b0, CTRL, 8'h00, 8'h00}};
    logic clock_i = 1'b0;
    logic rst_n_i, scl, vin_rise, vin_fall, hot, hk_ok, dvs, wr_strobe, rd, rvalid, ready, hk_power;
    logic uvlo_arm, buck_en, soft_start, pd_en, ok;
    logic [7:0] addr, wdata, rdata, d;
    logic [1:0] state, pd_sel;
    int num_errors = 0;
    int checks_done = 0;
    always #25 clock_i = ~clock_i;
    regulator_state_sequencer #(.SCL_LOW_CYCLES(200), .FAULT_WAIT_CYCLES(FW),
        .SOFT_START_CYCLES(SS)) regulator_state_sequencer_i (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .scl_i(scl), .vin_above_rise_i(vin_rise),
        .vin_below_fall_i(vin_fall), .over_temp_i(hot), .hk_stable_i(hk_ok),
        .dvs_falling_i(dvs), .reg_wr_i(wr_strobe), .reg_rd_i(rd), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .state_o(state),
        .ready_o(ready), .hk_power_o(hk_power), .uvlo_arm_o(uvlo_arm), .buck_en_o(buck_en),
        .soft_start_o(soft_start), .pulldown_en_o(pd_en), .pulldown_sel_o(pd_sel));
    regulator_host_model regulator_host_model_i (.clock_i(clock_i), .reg_rdata_i(rdata),
        .reg_rvalid_i(rvalid), .scl_o(scl), .reg_wr_o(wr_strobe), .reg_rd_o(rd), .reg_addr_o(addr),
        .reg_wdata_o(wdata));
    task automatic cyc(input int n);
        repeat (n) @(posedge clock_i);
    endtask : cyc
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t ns: got %h, want %h", $time, got, exp);
        end
    endtask : check
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        regulator_host_model_i.read_reg(a, d, ok);
        check({7'h0, ok}, 8'h01);
        check(d, exp);
    endtask : rd_chk
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        regulator_host_model_i.write_reg(a, v);
        #1;
    endtask : wr
    task automatic conclude;
        $display("checks %0d, mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : conclude
    initial begin
        cyc(20000);
        num_errors++;
        $display("unexpected at %0t ns: watchdog expired", $time);
        conclude();
    end
    initial begin
        {rst_n_i, vin_rise, vin_fall, hot, hk_ok, dvs} = 6'b010010;
        cyc(8);
        rst_n_i <= 1'b1;
        cyc(20);
        #1 check({6'h0, state}, RST);
        check({6'h0, pd_sel}, {6'h0, `SHDN_SEL_RST});
        regulator_host_model_i.read_reg(8'h02, d, ok);
        check({7'h0, ok}, 8'h00);
        regulator_host_model_i.release_scl(400);
        check({6'h0, state}, IDL);
        check({6'h0, ready, uvlo_arm}, 8'h03);
        $display("test power_up done");
        foreach (rows[i]) begin
            if (rows[i].wr) regulator_host_model_i.write_reg(rows[i].addr, rows[i].data);
            rd_chk(rows[i].addr, rows[i].exp);
            if (rows[i].wr) check({6'h0, pd_sel}, {6'h0, rows[i].data[1:0]});
        end
        $display("test register rows done");
        wr(CTRL, 8'h01);
        check({6'h0, state}, ACT);
        check({6'h0, buck_en, soft_start}, 8'h03);
        cyc(SS + 2);
        #1 check({7'h0, soft_start}, 8'h00);
        dvs <= 1'b1;
        cyc(2);
        #1 check({7'h0, pd_en}, 8'h01);
        dvs <= 1'b0;
        cyc(3);
        #1 check({7'h0, pd_en}, 8'h00);
        rd_chk(CTRL, 8'h01);
        wr(CTRL, 8'h00);
        check({6'h0, state}, IDL);
        cyc(41);
        #1 check({7'h0, pd_en}, 8'h01);
        wr(SHDN, 8'h00);
        wr(CTRL, 8'h01);
        wr(CTRL, 8'h00);
        cyc(45);
        #1 check({7'h0, pd_en}, 8'h00);
        $display("test enable and discharge done");
        wr(SHDN, 8'h02);
        wr(CTRL, 8'h01);
        hot <= 1'b1;
        cyc(8);
        #1 check({6'h0, state}, IDL);
        rd_chk(8'h02, 8'h04);
        rd_chk(8'h01, 8'h04);
        wr(CTRL, 8'h01);
        rd_chk(CTRL, 8'h00);
        hot <= 1'b0;
        cyc(20);
        #1 check({7'h0, ready}, 8'h00);
        cyc(FW);
        rd_chk(8'h02, 8'h01);
        rd_chk(8'h01, 8'h04);
        rd_chk(8'h01, 8'h00);
        wr(CTRL, 8'h01);
        check({6'h0, state}, ACT);
        $display("test over-temperature done");
        vin_fall <= 1'b1;
        vin_rise <= 1'b0;
        cyc(8);
        #1 check({6'h0, state, buck_en}, {IDL[6:0], 1'b0});
        rd_chk(8'h02, 8'h02);
        vin_fall <= 1'b0;
        vin_rise <= 1'b1;
        cyc(FW + 10);
        rd_chk(8'h02, 8'h01);
        $display("test input drop done");
        wr(SHDN, 8'h03);
        wr(`REG_RESET_ADDR, `RESET_CODE);
        cyc(3);
        #1 check({6'h0, state}, IDL);
        rd_chk(SHDN, 8'h02);
        $display("test software reset done");
        regulator_host_model_i.pull_scl(150);
        regulator_host_model_i.release_scl(10);
        check({6'h0, state, hk_power}, {IDL[6:0], 1'b1});
        // two short lows must not add up to a long one
        regulator_host_model_i.pull_scl(150);
        #1 check({6'h0, state}, IDL);
        regulator_host_model_i.release_scl(10);
        vin_rise <= 1'b0;
        regulator_host_model_i.pull_scl(260);
        #1 check({6'h0, state, hk_power}, 8'h00);
        regulator_host_model_i.release_scl(400);
        check({6'h0, state, ready}, {IDL[6:0], 1'b0});
        rd_chk(8'h01, 8'h02);
        wr(CTRL, 8'h01);
        check({6'h0, state}, IDL);
        rd_chk(8'h01, 8'h02);
        vin_rise <= 1'b1;
        hk_ok <= 1'b0;
        cyc(FW + 10);
        #1 check({7'h0, ready}, 8'h00);
        hk_ok <= 1'b1;
        cyc(8);
        #1 check({7'h0, ready}, 8'h01);
        $display("test line-low reset done");
        conclude();
    end
endmodule : regulator_state_sequencer_bench
